// *** timers_cfg.svh ***
// Summary of operation
// - Three identical channels: 16-bit pre-load, 16-bit down-counter, clock select, irq.
// - A bus write to a channel stores the 16-bit word in its pre-load.
// - Pre-load moves into the counter on the next selected clock event.
// - Each later selected clock event decrements the counter by one.
// - At zero the counter reloads on the next event and keeps counting.
// - Pre-load of zero gives a full period of 65536 events.
// - All updates happen on the processor clock, counting qualified by the tick or a pin edge.
// - Reading a channel returns its count without disturbing counting.
// - Each channel raises an interrupt request when its counter decrements to zero.
// - Each request is gated by its mask bit.
// - Request stays latched until the acknowledge for its level clears it.
// - Pin-usage bits 9:8 assign pins three, four, five to counters or irqs.
// - A counter without an assigned pin is decremented by the timer tick.
// - An irq input whose pin went to a counter is held inactive.
`ifndef TIMERS_CFG_SVH
`define TIMERS_CFG_SVH
`define CNT_WIDTH      16
`define CHAN_COUNT     3
`define PIN_USE_LO     8
`define PIN_USE_HI     9
`define PRELOAD_RESET  16'h0000
`define COUNT_RESET    16'h0000
`endif

// *** timers_pkg.sv ***
package timers_pkg;
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [1:0]  chan;
		logic [15:0] data;
	} bus_req_type;
endpackage : timers_pkg

// *** triple_down_counter_timers.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "timers_cfg.svh"
module triple_down_counter_timers
	import timers_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  sys_rst_i,
	// Internal timer tick, one-cycle enable
	input  wire logic                  timer_tick_i,
	// Peripheral bus access
	input  wire bus_req_type           bus_req_i,
	output logic [15:0]                rd_data_o,
	// Pin-usage field from interrupt base control bits 9:8
	input  wire logic [1:0]            interrupt_base_control_i,
	// Shared external pins
	input  wire logic                  ext_input_three_i,
	input  wire logic                  ext_input_four_i,
	input  wire logic                  ext_input_five_i,
	// Interrupt controller side
	input  wire logic [2:0]            irq_mask_i,
	input  wire logic [2:0]            irq_ack_i,
	output logic [2:0]                 irq_o,
	output logic                       irq_level_ten_o,
	output logic                       irq_level_eleven_o,
	output logic                       irq_level_twelve_o,
	// Current counts for observation
	output logic [3*`CNT_WIDTH-1:0]    count_o
);
	localparam int N = `CHAN_COUNT;
	// Each channel counts on a one-cycle event: the tick, or a
	// synchronised rising edge of its shared pin. A written pre-load
	// waits for that event before it reaches the counter, so the
	// core never sees a half-updated count. Reads sample the count
	// register and have no side effect on counting.
	logic [2:0]  pin_meta_q;
	logic [2:0]  pin_sync_q;
	logic [2:0]  pin_old_q;
	logic [2:0]  pin_rise;
	logic [2:0]  ext_sel;
	logic [2:0]  event_c;
	logic [15:0] preload_q [N];
	logic [15:0] count_q   [N];
	logic [N-1:0] pend_q;
	logic [N-1:0] load_pend_q;
	logic [N-1:0] zero_hit;

	// Two-stage pin synchroniser
	// Only the second and third stages feed logic; the first may be metastable.
	// The third stage keeps the previous level for edge detection.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pin_meta_q <= 3'h0;
			pin_sync_q <= 3'h0;
			pin_old_q  <= 3'h0;
		end else begin
			pin_meta_q <= {ext_input_five_i, ext_input_four_i,
			               ext_input_three_i};
			pin_sync_q <= pin_meta_q;
			pin_old_q  <= pin_sync_q;
		end
	end
	assign pin_rise = pin_sync_q & ~pin_old_q;

	assign ext_sel[0] = (interrupt_base_control_i != 2'h0);
	assign ext_sel[1] = interrupt_base_control_i[1];
	assign ext_sel[2] = (interrupt_base_control_i == 2'h3);

	assign event_c = (ext_sel & pin_rise) | (~ext_sel & {3{timer_tick_i}});

	// Pins given to counters hold irq inputs inactive
	assign irq_level_ten_o    = ~ext_sel[0] & pin_sync_q[0];
	assign irq_level_eleven_o = ~ext_sel[1] & pin_sync_q[1];
	assign irq_level_twelve_o = ~ext_sel[2] & pin_sync_q[2];

	genvar g;
	generate
		// Three identical channels
		// Every channel has its own pre-load, load flag, counter and
		// latched request; only the event source differs between them.
		// A write and an event in one cycle keep the load pending.
		for (g = 0; g < N; g++) begin : g_chan
			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					preload_q[g] <= `PRELOAD_RESET;
				end else if (bus_req_i.wr && bus_req_i.chan == 2'(g)) begin
					preload_q[g] <= bus_req_i.data;
				end
			end
			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					load_pend_q[g] <= 1'b0;
				end else if (bus_req_i.wr && bus_req_i.chan == 2'(g)) begin
					load_pend_q[g] <= 1'b1;
				end else if (event_c[g]) begin
					load_pend_q[g] <= 1'b0;
				end
			end
			// Count, reload at zero, zero wraps
			// A zero pre-load is not reloaded at zero; the counter
			// wraps to FFFF instead, so the period is a full 65536.
			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					count_q[g] <= `COUNT_RESET;
				end else if (event_c[g]) begin
					if (load_pend_q[g]) begin
						count_q[g] <= preload_q[g];
					end else if (count_q[g] == 16'h0000 &&
					             preload_q[g] != 16'h0000) begin
						count_q[g] <= preload_q[g];
					end else begin
						count_q[g] <= count_q[g] - 16'h0001;
					end
				end
			end
			// Zero reached by decrement, not by loading zero
			assign zero_hit[g] = event_c[g] && !load_pend_q[g] &&
			                     count_q[g] == 16'h0001;
			// Latched request, set wins over ack
			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					pend_q[g] <= 1'b0;
				end else if (zero_hit[g]) begin
					pend_q[g] <= 1'b1;
				end else if (irq_ack_i[g]) begin
					pend_q[g] <= 1'b0;
				end
			end
			assign count_o[g*16 +: 16] = count_q[g];

			a_pend_hold: assert property (@(posedge clk_i)
				disable iff (sys_rst_i)
				pend_q[g] && !irq_ack_i[g] |=> pend_q[g])
				else $error("request dropped without ack");
			a_dec_one: assert property (@(posedge clk_i)
				disable iff (sys_rst_i)
				event_c[g] && !load_pend_q[g] && count_q[g] != 16'h0000
				|=> count_q[g] == $past(count_q[g]) - 16'h0001)
				else $error("counter did not decrement by one");
			a_zero_reload: assert property (@(posedge clk_i)
				disable iff (sys_rst_i)
				event_c[g] && count_q[g] == 16'h0000 &&
				preload_q[g] != 16'h0000
				|=> count_q[g] == $past(preload_q[g]))
				else $error("counter did not reload at zero");
			// First event after write loads pre-load
			a_load_next: assert property (@(posedge clk_i)
				disable iff (sys_rst_i)
				load_pend_q[g] && event_c[g]
				|=> count_q[g] == $past(preload_q[g]))
				else $error("pre-load not taken on event");
			a_hold_idle: assert property (@(posedge clk_i)
				disable iff (sys_rst_i)
				!event_c[g] |=> $stable(count_q[g]))
				else $error("count changed without event");
			a_zero_irq: assert property (@(posedge clk_i)
				disable iff (sys_rst_i)
				zero_hit[g] |=> pend_q[g] && count_q[g] == 16'h0000)
				else $error("no request at zero");
			a_zero_wrap: assert property (@(posedge clk_i)
				disable iff (sys_rst_i)
				event_c[g] && !load_pend_q[g] && count_q[g] == 16'h0000
				&& preload_q[g] == 16'h0000
				|=> count_q[g] == 16'hFFFF)
				else $error("zero pre-load did not wrap");
			a_pend_ack: assert property (@(posedge clk_i)
				disable iff (sys_rst_i)
				pend_q[g] && irq_ack_i[g] && !zero_hit[g]
				|=> !pend_q[g])
				else $error("request not cleared by ack");
			a_wr_preload: assert property (@(posedge clk_i)
				disable iff (sys_rst_i)
				bus_req_i.wr && bus_req_i.chan == 2'(g)
				|=> preload_q[g] == $past(bus_req_i.data))
				else $error("write did not store pre-load");
			a_wr_pend: assert property (@(posedge clk_i)
				disable iff (sys_rst_i)
				bus_req_i.wr && bus_req_i.chan == 2'(g)
				|=> load_pend_q[g])
				else $error("write did not arm the load");
			a_load_clear: assert property (@(posedge clk_i)
				disable iff (sys_rst_i)
				load_pend_q[g] && event_c[g] &&
				!(bus_req_i.wr && bus_req_i.chan == 2'(g))
				|=> !load_pend_q[g])
				else $error("load stayed pending after event");
			a_mask_off: assert property (@(posedge clk_i)
				disable iff (sys_rst_i)
				!irq_mask_i[g] |-> !irq_o[g])
				else $error("masked request reached output");
			a_mask_pass: assert property (@(posedge clk_i)
				disable iff (sys_rst_i)
				irq_mask_i[g] && pend_q[g] |-> irq_o[g])
				else $error("unmasked request not shown");
			a_tick_source: assert property (@(posedge clk_i)
				disable iff (sys_rst_i)
				!ext_sel[g] |-> event_c[g] == timer_tick_i)
				else $error("tick counter has wrong event");
			a_pin_source: assert property (@(posedge clk_i)
				disable iff (sys_rst_i)
				ext_sel[g] |-> event_c[g] == pin_rise[g])
				else $error("pin counter has wrong event");
			a_edge_once: assert property (@(posedge clk_i)
				disable iff (sys_rst_i)
				ext_sel[g] && event_c[g] ##1 ext_sel[g]
				|-> !event_c[g])
				else $error("two events from one pin edge");
			a_rd_value: assert property (@(posedge clk_i)
				disable iff (sys_rst_i)
				bus_req_i.rd && bus_req_i.chan == 2'(g)
				|=> rd_data_o == $past(count_q[g]))
				else $error("read data is not the count");
			a_rd_quiet: assert property (@(posedge clk_i)
				disable iff (sys_rst_i)
				bus_req_i.rd && !event_c[g]
				|=> $stable(count_q[g]))
				else $error("read disturbed the count");
		end
	endgenerate

	assign irq_o = pend_q & irq_mask_i;

	// Read returns count, no side effect
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rd_data_o <= 16'h0000;
		end else if (bus_req_i.rd && bus_req_i.chan < 2'(N)) begin
			rd_data_o <= count_q[bus_req_i.chan];
		end else if (bus_req_i.rd) begin
			rd_data_o <= 16'h0000;
		end
	end

	a_irq_inactive: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		ext_sel[0] |-> !irq_level_ten_o)
		else $error("irq ten active while pin is a clock");
	// Pin four as clock stays quiet
	a_irq_quiet_four: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		ext_sel[1] |-> !irq_level_eleven_o)
		else $error("irq eleven active while pin is a clock");
	// Pin five as clock stays quiet
	a_irq_quiet_five: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		ext_sel[2] |-> !irq_level_twelve_o)
		else $error("irq twelve active while pin is a clock");
	a_mask_gate: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		!irq_mask_i[1] |-> !irq_o[1])
		else $error("masked request reached output");
	a_edge_event: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		ext_sel[0] && event_c[0] |=> !event_c[0])
		else $error("double event from one edge");
	// Field zero keeps all pins for irqs
	a_use_none: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		interrupt_base_control_i == 2'h0 |-> ext_sel == 3'h0)
		else $error("pin given to a counter with field zero");
	a_use_one: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		interrupt_base_control_i == 2'h1 |-> ext_sel == 3'h1)
		else $error("wrong pins for field one");
	// Field two clocks counters zero, one
	a_use_two: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		interrupt_base_control_i == 2'h2 |-> ext_sel == 3'h3)
		else $error("wrong pins for field two");
	a_use_all: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		interrupt_base_control_i == 2'h3 |-> ext_sel == 3'h7)
		else $error("wrong pins for field three");
	a_rd_refuse: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		bus_req_i.rd && bus_req_i.chan == 2'h3
		|=> rd_data_o == 16'h0000)
		else $error("read of unused channel not zero");
	a_rd_hold: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		!bus_req_i.rd |=> $stable(rd_data_o))
		else $error("read data changed without a read");
endmodule : triple_down_counter_timers
`default_nettype wire

// *** bus_core_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module bus_core_model
	import timers_pkg::*;
(
	// Clock and read data
	input  wire logic        clk_i,
	input  wire logic [15:0] rd_data_i,
	// Requests toward the timers
	output var bus_req_type  bus_req_o
);
	// One-cycle write pulse, launched off the falling edge
	task automatic write(input logic [1:0] ch, input logic [15:0] d);
		@(negedge clk_i);
		bus_req_o = '{wr: 1'b1, rd: 1'b0, chan: ch, data: d};
		@(negedge clk_i);
		bus_req_o = '0;
	endtask : write
	// Read pulse; data is registered on the taking edge and sampled at the second falling edge after it
	task automatic read(input logic [1:0] ch, output logic [15:0] d);
		@(negedge clk_i);
		bus_req_o = '{wr: 1'b0, rd: 1'b1, chan: ch, data: 16'h0000};
		@(negedge clk_i);
		bus_req_o = '0;
		@(negedge clk_i);
		d = rd_data_i;
	endtask : read
	initial bus_req_o = '0;
endmodule : bus_core_model
`default_nettype wire

// *** triple_down_counter_timers_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module triple_down_counter_timers_bench;
	import timers_pkg::*;
	logic clk = 0, sys_rst = 1, tick = 0, e3 = 0, e4 = 0, e5 = 0;
	logic [1:0] interrupt_base_control = 2'h0;
	logic [2:0] mask = 3'h0, ack = 3'h0, irq;
	logic l10, l11, l12;
	logic [15:0] rd;
	logic [47:0] cnt;
	bus_req_type req;
	int failures = 0, tests_run = 0;
	always #2.5 clk = ~clk;
	bus_core_model u_bus_core_model (.clk_i(clk), .rd_data_i(rd),
		.bus_req_o(req));
	triple_down_counter_timers u_triple_down_counter_timers (.clk_i(clk),
		.sys_rst_i(sys_rst), .timer_tick_i(tick), .bus_req_i(req),
		.rd_data_o(rd), .interrupt_base_control_i(interrupt_base_control),
		.ext_input_three_i(e3), .ext_input_four_i(e4),
		.ext_input_five_i(e5), .irq_mask_i(mask), .irq_ack_i(ack),
		.irq_o(irq), .irq_level_ten_o(l10), .irq_level_eleven_o(l11),
		.irq_level_twelve_o(l12), .count_o(cnt));
	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// One tick pulse, one cycle wide
	task automatic pulse_tick();
		@(negedge clk) tick = 1;
		@(negedge clk) tick = 0;
	endtask : pulse_tick
	// Slow pin pulse, well under half the clock rate
	task automatic pulse_pin();
		@(negedge clk) e3 = 1;
		repeat (4) @(negedge clk);
		e3 = 0;
		repeat (4) @(negedge clk);
	endtask : pulse_pin
	// Load, count down, reload at zero, interrupt latch
	task automatic test_load();
		logic [15:0] v;
		u_bus_core_model.write(2'h0, 16'h0003);
		chk(cnt[15:0], 16'h0000);
		pulse_tick();
		chk(cnt[15:0], 16'h0003);
		pulse_tick();
		chk(cnt[15:0], 16'h0002);
		pulse_tick();
		pulse_tick();
		@(negedge clk);
		chk(cnt[15:0], 16'h0000);
		chk({15'h0, irq[0]}, 16'h0000);
		mask = 3'h7;
		@(negedge clk);
		chk({15'h0, irq[0]}, 16'h0001);
		u_bus_core_model.read(2'h0, v);
		chk(v, 16'h0000);
		pulse_tick();
		chk(cnt[15:0], 16'h0003);
		@(negedge clk) ack = 3'h1;
		@(negedge clk) ack = 3'h0;
		chk({15'h0, irq[0]}, 16'h0000);
		$display("test_load done");
	endtask : test_load
	// Pin clocking and level gating
	task automatic test_pin();
		interrupt_base_control = 2'h1;
		u_bus_core_model.write(2'h1, 16'h0004);
		u_bus_core_model.write(2'h0, 16'h0002);
		pulse_tick();
		chk(cnt[31:16], 16'h0004);
		chk(cnt[15:0], 16'h0003);
		pulse_pin();
		chk(cnt[15:0], 16'h0002);
		chk({15'h0, l10}, 16'h0000);
		interrupt_base_control = 2'h0;
		@(negedge clk) e3 = 1;
		repeat (4) @(negedge clk);
		chk({15'h0, l10}, 16'h0001);
		e3 = 0;
		$display("test_pin done");
	endtask : test_pin
	// Zero pre-load runs a full 65536-event period
	task automatic test_wrap();
		logic [15:0] v;
		u_bus_core_model.write(2'h2, 16'h0000);
		@(negedge clk) tick = 1;
		@(negedge clk);
		chk(cnt[47:32], 16'h0000);
		@(negedge clk);
		chk(cnt[47:32], 16'hFFFF);
		repeat (65535) @(negedge clk);
		tick = 0;
		chk(cnt[47:32], 16'h0000);
		chk({15'h0, irq[2]}, 16'h0001);
		@(negedge clk) ack = 3'h7;
		@(negedge clk) ack = 3'h0;
		u_bus_core_model.read(2'h3, v);
		chk(v, 16'h0000);
		$display("test_wrap done");
	endtask : test_wrap
	// Pins four and five as counter clocks, then as irq levels
	task automatic test_levels();
		@(negedge clk) interrupt_base_control = 2'h3;
		e4 = 1;
		e5 = 1;
		repeat (4) @(negedge clk);
		chk({15'h0, l11}, 16'h0000);
		chk({15'h0, l12}, 16'h0000);
		chk(cnt[47:32], 16'hFFFF);
		interrupt_base_control = 2'h0;
		@(negedge clk);
		chk({14'h0, l12, l11}, 16'h0003);
		e4 = 0;
		e5 = 0;
		$display("test_levels done");
	endtask : test_levels
	// Verdict
	task automatic end_of_test();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (4) @(negedge clk);
		sys_rst = 0;
		test_load();
		test_pin();
		test_wrap();
		test_levels();
		end_of_test();
	end
	// Watchdog
	initial begin
		#(5 * 80000);
		failures++;
		end_of_test();
	end
endmodule : triple_down_counter_timers_bench
`default_nettype wire
